//--- common/wdc_pkg.sv
/*
 * Shared constants for the watchdog control block: register offset,
 * field positions, reset values and timing figures.
 * Assumes a 32-bit plain register port with a byte address.
 */
`default_nettype none

package wdc_pkg;

    // Register map
    localparam logic [7:0] CONTROL_OFFSET = 8'h00;  // Control word offset

    // Field positions in the control word
    localparam int RUN_BIT = 15;            // Run control
    localparam int SHADOW_HI = 6;           // Shadow postscale top bit
    localparam int SHADOW_LO = 2;           // Shadow postscale low bit
    localparam int WINDOW_BIT = 1;          // Window enable
    localparam int CLEAR_BIT = 0;           // Count clear strobe

    // Postscale range
    localparam logic [4:0] POSTSCALE_MAX = 5'h14;   // Largest code, 1:1048576

    // Values after reset
    localparam logic RUN_RESET = 1'h0;      // Software enable off
    localparam logic WINDOW_RESET = 1'h0;   // Non-windowed
    localparam logic [31:0] READ_RESET = 32'h0000_0000;  // Read data idle

    // Timer figures
    localparam int BASE_TICK_CYCLES = 200;  // Clock cycles per base tick
    localparam int TIMEOUT_TICKS = 1024;    // Postscaled ticks to expiry
    localparam int WINDOW_TICKS = 768;      // Clears before this are early
    localparam int RESET_PULSE_CYCLES = 4;  // Reset request length

endpackage : wdc_pkg

`default_nettype wire

//--- common/wdc_tick_if.sv
/*
 * Interface between the control block and its postscaler.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

interface wdc_tick_if;
    logic run;           // Watchdog running
    logic restart;       // Restart postscaler count
    logic [4:0] code;    // Postscale code
    logic tick;          // One postscaled tick

    // Control side
    modport ctrl (output run, output restart, output code, input tick);
    // Postscaler side
    modport scaler (input run, input restart, input code, output tick);
endinterface : wdc_tick_if

`default_nettype wire

//--- src/wdc_postscaler.sv
/*
 * Postscaler: divides a base tick by two raised to the shadow code.
 * Assumes the control block drives run, restart and code on clk.
 */
`timescale 1ns/1ps
`default_nettype none

module wdc_postscaler #(
    parameter int BASE_CYCLES = wdc_pkg::BASE_TICK_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Control side
    wdc_tick_if.scaler tk
);

    // Refuse a base divider the counter cannot serve, at elaboration
    if (BASE_CYCLES < 1)
    begin : g_bad_base
        $error("BASE_CYCLES must be at least 1");
    end

    localparam int BW = $clog2(BASE_CYCLES + 1);

    logic [BW-1:0] base_count;       // Base divider
    logic [BW-1:0] next_base_count;
    logic [20:0] post_count;         // Postscale counter
    logic [20:0] next_post_count;
    logic tick;                      // Registered tick
    logic next_tick;
    logic [4:0] eff_code;            // Clamped code

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb
    begin
        // Codes beyond the top behave as the top
        eff_code = (tk.code > wdc_pkg::POSTSCALE_MAX) ? wdc_pkg::POSTSCALE_MAX
                                                     : tk.code;
        next_base_count = base_count;
        next_post_count = post_count;
        next_tick = 1'b0;
        if (!tk.run || tk.restart)
        begin
            // Stopped or cleared: start from zero
            next_base_count = '0;
            next_post_count = '0;
        end
        else if (base_count == BW'(BASE_CYCLES - 1))
        begin
            next_base_count = '0;
            // Divide by two to the code
            if (post_count >= ((21'h1 << eff_code) - 21'h1))
            begin
                next_post_count = '0;
                next_tick = 1'b1;
            end
            else
            begin
                next_post_count = post_count + 21'h1;
            end
        end
        else
        begin
            next_base_count = base_count + BW'(1);
        end
    end

    // Registers
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            base_count <= '0;
            post_count <= '0;
            tick <= 1'b0;
        end
        else
        begin
            base_count <= next_base_count;
            post_count <= next_post_count;
            tick <= next_tick;
        end
    end

    assign tk.tick = tick;

    // Tick only while running
    a_tick_needs_run: assert property (@(posedge clk) disable iff (!reset_n)
        tick |-> $past(tk.run)) else $error("tick while stopped");

endmodule : wdc_postscaler

`default_nettype wire

//--- src/wdc_watchdog.sv
/*
 * Watchdog control register and timeout counter.
 * Assumes the configuration word is stable and arrives from another
 * domain; software uses a plain one-cycle register port.
 */
`timescale 1ns/1ps
`default_nettype none

module wdc_watchdog #(
    parameter int BASE_CYCLES = wdc_pkg::BASE_TICK_CYCLES,
    parameter int TIMEOUT = wdc_pkg::TIMEOUT_TICKS,
    parameter int WINDOW = wdc_pkg::WINDOW_TICKS
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    // Configuration word
    input wire logic config_watchdog_enable,
    input wire logic config_window_disable,
    input wire logic [4:0] config_postscale,
    // Watchdog outputs
    output logic reset_request,
    output logic running
);

    // Refuse counts the logic cannot serve, at elaboration
    if (TIMEOUT < 2 || WINDOW < 1 || WINDOW >= TIMEOUT)
    begin : g_bad_counts
        $error("watchdog counts out of range");
    end

    localparam int TW = $clog2(TIMEOUT + 1);
    localparam logic [TW-1:0] LAST = TW'(TIMEOUT - 1);
    localparam logic [TW-1:0] OPEN = TW'(WINDOW);
    localparam logic [2:0] PULSE_LAST = 3'(wdc_pkg::RESET_PULSE_CYCLES - 1);

    typedef enum logic [1:0] {
        WDC_LOAD = 2'b00,   // Catch configuration after reset
        WDC_RUN = 2'b01,    // Normal operation
        WDC_FIRE = 2'b10    // Holding reset request
    } wdc_state_t;

    // Synchronisers for configuration inputs
    logic [6:0] cfg_meta;            // First stage
    logic [6:0] cfg_sync;            // Second stage

    // Control state
    wdc_state_t state, next_state;
    logic sw_run, next_sw_run;               // Software enable
    logic window_en, next_window_en;         // Window enable
    logic [4:0] shadow, next_shadow;         // Shadow postscale
    logic [TW-1:0] count, next_count;        // Postscaled tick count
    logic [2:0] pulse, next_pulse;           // Reset pulse length
    logic [31:0] rdata, next_rdata;          // Read data
    logic req, next_req;                     // Reset request
    logic run_q, next_run_q;                 // Running flag
    logic clear_now;                         // Clear strobe this cycle
    logic wr_ctrl;                           // Write to control word

    wdc_tick_if tk ();

    // Control word decode, used for reads and writes
    function automatic logic hit(input logic [7:0] a);
        hit = (a == wdc_pkg::CONTROL_OFFSET);
    endfunction : hit

    ////////////////////////////////////////////////////////////////////////
    // Configuration synchroniser: pins are from outside clk
    // Kept out of reset so it goes on sampling while reset is held;
    // otherwise the shadow would load zeros at the first edge after release
    always_ff @(posedge clk)
    begin
        cfg_meta <= {config_watchdog_enable, config_window_disable,
                     config_postscale};
        cfg_sync <= cfg_meta;
    end

    ////////////////////////////////////////////////////////////////////////
    // Control next state
    always_comb
    begin
        wr_ctrl = reg_write && hit(reg_addr);
        clear_now = wr_ctrl && reg_wdata[wdc_pkg::CLEAR_BIT];
        next_state = state;
        next_sw_run = sw_run;
        next_window_en = window_en;
        next_shadow = shadow;
        next_count = count;
        next_pulse = pulse;
        next_req = 1'b0;
        case (state)
            WDC_LOAD:
            begin
                // Shadow caught once synchronised config is settled
                next_shadow = cfg_sync[4:0];
                next_window_en = ~cfg_sync[5];
                next_count = '0;
                next_state = WDC_RUN;
            end
            WDC_RUN:
            begin
                if (wr_ctrl)
                begin
                    // Write sets or clears the software enable and the window enable
                    next_sw_run = reg_wdata[wdc_pkg::RUN_BIT];
                    next_window_en = reg_wdata[wdc_pkg::WINDOW_BIT];
                end
                if (!run_q || clear_now)
                begin
                    // Early clear in windowed mode is a violation
                    if (run_q && clear_now && window_en && count < OPEN)
                    begin
                        next_state = WDC_FIRE;
                        next_pulse = '0;
                        next_req = 1'b1;
                    end
                    next_count = '0;
                end
                else if (tk.tick)
                begin
                    if (count == LAST)
                    begin
                        next_state = WDC_FIRE;
                        next_pulse = '0;
                        next_req = 1'b1;
                        next_count = '0;
                    end
                    else
                    begin
                        next_count = count + TW'(1);
                    end
                end
            end
            WDC_FIRE:
            begin
                // Hold request a fixed number of cycles
                next_req = (pulse != PULSE_LAST);
                next_pulse = pulse + 3'h1;
                if (pulse == PULSE_LAST)
                begin
                    next_state = WDC_LOAD;
                    next_sw_run = wdc_pkg::RUN_RESET;
                end
            end
            default:
            begin
                next_state = WDC_LOAD;
            end
        endcase
        // Config enable cannot be turned off by software
        next_run_q = cfg_sync[6] || next_sw_run;
        // Read data: only defined fields, zero elsewhere
        next_rdata = '0;
        if (reg_read && hit(reg_addr))
        begin
            next_rdata[wdc_pkg::RUN_BIT] = run_q;
            next_rdata[wdc_pkg::SHADOW_HI:wdc_pkg::SHADOW_LO] = shadow;
            next_rdata[wdc_pkg::WINDOW_BIT] = window_en;
        end
    end

    // Control registers
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state <= WDC_LOAD;
            sw_run <= wdc_pkg::RUN_RESET;
            window_en <= wdc_pkg::WINDOW_RESET;
            shadow <= '0;
            count <= '0;
            pulse <= '0;
            rdata <= wdc_pkg::READ_RESET;
            req <= 1'b0;
            run_q <= 1'b0;
        end
        else
        begin
            state <= next_state;
            sw_run <= next_sw_run;
            window_en <= next_window_en;
            shadow <= next_shadow;
            count <= next_count;
            pulse <= next_pulse;
            rdata <= next_rdata;
            req <= next_req;
            run_q <= next_run_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Postscaler
    assign tk.run = run_q && (state == WDC_RUN);
    assign tk.restart = clear_now;
    assign tk.code = shadow;

    wdc_postscaler #(.BASE_CYCLES(BASE_CYCLES)) u_scaler (
        .clk(clk),
        .reset_n(reset_n),
        .tk(tk)
    );

    assign reg_rdata = rdata;
    assign reset_request = req;
    assign running = run_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_run_set_start: assert property (@(posedge clk) disable iff (!reset_n)
        (state == WDC_RUN && wr_ctrl && reg_wdata[15]) |=> running)
        else $error("run write did not start");
    a_config_holds_run: assert property (@(posedge clk) disable iff (!reset_n)
        cfg_sync[6] |=> running)
        else $error("config enable not honoured");
    a_sw_stop_only: assert property (@(posedge clk) disable iff (!reset_n)
        (state == WDC_RUN && wr_ctrl && !reg_wdata[15] && !cfg_sync[6]
         && $stable(cfg_sync[6])) |=> !running)
        else $error("software stop failed");
    a_read_run_bit: assert property (@(posedge clk) disable iff (!reset_n)
        (reg_read && hit(reg_addr)) |=> reg_rdata[15] == $past(run_q))
        else $error("run bit readback wrong");
    a_read_zero_bits: assert property (@(posedge clk) disable iff (!reset_n)
        reg_rdata[31:16] == 16'h0000 && reg_rdata[14:7] == 8'h00)
        else $error("unimplemented bits not zero");
    a_shadow_load: assert property (@(posedge clk) disable iff (!reset_n)
        (state == WDC_LOAD) |=> shadow == $past(cfg_sync[4:0]))
        else $error("shadow not loaded");
    a_clear_restart: assert property (@(posedge clk) disable iff (!reset_n)
        (state == WDC_RUN && clear_now) |=> count == '0)
        else $error("clear did not restart");
    a_window_write: assert property (@(posedge clk) disable iff (!reset_n)
        (state == WDC_RUN && wr_ctrl) |=> window_en == $past(reg_wdata[1]))
        else $error("window enable not stored");
    a_expiry_fires: assert property (@(posedge clk) disable iff (!reset_n)
        (state == WDC_RUN && run_q && !clear_now && tk.tick && count == LAST)
        |=> reset_request [*4])
        else $error("expiry did not request reset");

endmodule : wdc_watchdog

`default_nettype wire

//--- verif/watchdog_control_register_tb_top.sv
/*
 * Self-checking bench for the watchdog control block: register map,
 * software and configuration enables, clear strobe, expiry and window.
 * Assumes the design's short-count parameters and a 200 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none

module watchdog_control_register_tb_top;

    ////////////////////////////////////////////////////////////////////////
    // Stimulus and observed signals
    logic clk = 1'b0;                   // Bench clock
    logic reset_n = 1'b0;               // Async reset, active low
    logic [7:0] reg_addr = 8'h00;       // Register address
    logic [31:0] reg_wdata = 32'h0000_0000;  // Write data
    logic reg_write = 1'b0;             // Write strobe
    logic reg_read = 1'b0;              // Read strobe
    logic [31:0] reg_rdata;             // Read data
    logic cfg_en = 1'b0;                // Configuration enable
    logic cfg_windis = 1'b1;            // Configuration window disable
    logic [4:0] cfg_ps = 5'h03;         // Configuration postscale code
    logic reset_request;                // Device reset request
    logic running;                      // Watchdog enabled
    int error_cnt = 0;                  // Mismatch count
    int n_checks = 0;                   // Comparison count
    logic [31:0] got;                   // Last read word

    // 5 ns period
    always #2.5 clk = ~clk;

    // Short counts: eight cycles per tick at code 3, expiry after 32
    wdc_watchdog #(.BASE_CYCLES(1), .TIMEOUT(4), .WINDOW(2)) uut (
        .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .config_watchdog_enable(cfg_en), .config_window_disable(cfg_windis),
        .config_postscale(cfg_ps), .reset_request(reset_request), .running(running)
    );

    ////////////////////////////////////////////////////////////////////////
    // Compare and bus tasks
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
        n_checks++;
        if (exp !== seen)
        begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // Config held three edges before release so the shadow sees it
    task automatic do_reset(input logic en, input logic windis, input logic [4:0] ps);
        @(posedge clk);
        cfg_en <= en;
        cfg_windis <= windis;
        cfg_ps <= ps;
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge clk);
    endtask : do_reset

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask : wr

    // Data stand only in the cycle after the strobe edge
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1 got = reg_rdata;
    endtask : rd

    // Cycles until reset request, capped at the limit
    task automatic wait_req(input int lim, output int n);
        n = 0;
        while (reset_request !== 1'b1 && n < lim)
        begin
            @(posedge clk);
            #1 n++;
        end
    endtask : wait_req

    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_map;
        do_reset(1'b0, 1'b1, 5'h03);
        rd(8'h00);
        chk("reset word", 32'h0000_000C, got);
        wr(8'h00, 32'hFFFF_FFFC);
        @(posedge clk);
        #1 chk("sw run", 32'h1, running);
        rd(8'h00);
        chk("run word", 32'h0000_800C, got);
        wr(8'h00, 32'h0000_0000);
        @(posedge clk);
        #1 chk("sw stop", 32'h0, running);
        wr(8'h04, 32'h0000_8000);
        @(posedge clk);
        #1 chk("unmapped write", 32'h0, running);
        rd(8'h04);
        chk("unmapped read", 32'h0, got);
        $display("test map done");
    endtask : t_map

    task automatic t_clear_expire;
        int n;
        int hi;
        do_reset(1'b0, 1'b1, 5'h03);
        wr(8'h00, 32'h0000_8001);
        // Clears every 18 cycles keep a 32-cycle timer alive
        for (int i = 0; i < 6; i++)
        begin
            wait_req(16, n);
            chk("kept alive", 32'd16, n);
            wr(8'h00, 32'h0000_8001);
        end
        wait_req(60, n);
        chk("expiry span", 32'h1, 32'(n >= 20 && n <= 44));
        hi = 0;
        while (reset_request === 1'b1 && hi < 10)
        begin
            @(posedge clk);
            #1 hi++;
        end
        chk("pulse length", 32'd4, hi);
        repeat (3) @(posedge clk);
        #1 chk("sw enable dropped", 32'h0, running);
        $display("test clear and expiry done");
    endtask : t_clear_expire

    task automatic t_window;
        int n;
        do_reset(1'b0, 1'b1, 5'h03);
        wr(8'h00, 32'h0000_8002);
        rd(8'h00);
        chk("window word", 32'h0000_800E, got);
        wr(8'h00, 32'h0000_8003);
        wait_req(8, n);
        chk("early clear", 32'h1, 32'(n < 8));
        // Window mode chosen by the configuration word at reset
        do_reset(1'b0, 1'b0, 5'h03);
        rd(8'h00);
        chk("config window", 32'h0000_000E, got);
        $display("test window done");
    endtask : t_window

    task automatic t_config;
        do_reset(1'b1, 1'b1, 5'h14);
        #1 chk("cfg run", 32'h1, running);
        wr(8'h00, 32'h0000_0000);
        @(posedge clk);
        #1 chk("cfg stays", 32'h1, running);
        rd(8'h00);
        chk("cfg word", 32'h0000_8050, got);
        $display("test config done");
    endtask : t_config

    ////////////////////////////////////////////////////////////////////////
    // Verdict and run control
    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : conclude

    // Tests need well under 2000 cycles
    initial
    begin
        #20000;
        error_cnt++;
        conclude();
    end

    initial
    begin
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        t_map();
        t_clear_expire();
        t_window();
        t_config();
        conclude();
    end

endmodule : watchdog_control_register_tb_top

`default_nettype wire
